// ---- gpt_pkg.sv ----
// Package of shared constants for the general-purpose timer block
`default_nettype none

package gpt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned AXI_AW      = 8;
  localparam logic [7:0]  OFF_CTRL1   = 8'h00;
  localparam logic [7:0]  OFF_CTRL2   = 8'h04;
  localparam logic [7:0]  OFF_CTRL3   = 8'h08;
  localparam logic [7:0]  OFF_COUNT1  = 8'h0c;
  localparam logic [7:0]  OFF_PERIOD1 = 8'h10;
  localparam logic [7:0]  OFF_COUNT2  = 8'h14;
  localparam logic [7:0]  OFF_PERIOD2 = 8'h18;
  localparam logic [7:0]  OFF_COUNT3  = 8'h1c;
  localparam logic [7:0]  OFF_PERIOD3 = 8'h20;
  localparam logic [7:0]  OFF_STATUS  = 8'h24;
  localparam logic [7:0]  OFF_MASK    = 8'h28;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_RUN   = 15;
  localparam int unsigned BIT_IDLE  = 13;
  localparam int unsigned BIT_GATE  = 6;
  localparam int unsigned BIT_PS_HI = 5;
  localparam int unsigned BIT_PS_LO = 4;
  localparam int unsigned BIT_WIDE  = 3;
  localparam int unsigned BIT_SYNC  = 2;
  localparam int unsigned BIT_SRC   = 1;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL1_MASK = 16'ha076;
  localparam logic [15:0] CTRL2_MASK = 16'ha07a;
  localparam logic [15:0] CTRL3_MASK = 16'ha072;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [2:0]  STAT_RST   = 3'h0;

  // ----------------------------------------------------------------
  // Prescaler terminal counts and bus responses
  // ----------------------------------------------------------------
  localparam int unsigned PS_CNT_W    = 8;
  localparam logic [7:0]  PS_TERM_8   = 8'h07;
  localparam logic [7:0]  PS_TERM_64  = 8'h3f;
  localparam logic [7:0]  PS_TERM_256 = 8'hff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : gpt_pkg

`default_nettype wire

// ---- gpt_prescale.sv ----
// Input clock prescaler for one timer
`default_nettype none

module gpt_prescale
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic       step_in,
  input  wire logic [1:0] select_in,
  // Divided tick
  output logic            tick_out
);

  logic [PS_CNT_W-1:0] cnt;
  logic [PS_CNT_W-1:0] next_cnt;
  logic [PS_CNT_W-1:0] term;

  // Terminal count per ratio, tick at or past it so a smaller ratio takes at once
  always_comb begin
    case (select_in)
      2'h3:    term = PS_TERM_256;
      2'h2:    term = PS_TERM_64;
      2'h1:    term = PS_TERM_8;
      default: term = '0;
    endcase
    tick_out = step_in && (cnt >= term);
    next_cnt = cnt;
    if (clear_in) begin
      next_cnt = '0;
    end else if (step_in) begin
      next_cnt = tick_out ? '0 : cnt + 1'b1;
    end
  end

  // Count register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule : gpt_prescale

`default_nettype wire

// ---- gpt_timers.sv ----
// Three 16-bit timers with pairing, AXI4-Lite registers and interrupt
`default_nettype none

module gpt_timers
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  // AXI4-Lite write
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [AXI_AW-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Pins and CPU state
  input  wire logic              ext_clock_pin_one_in,
  input  wire logic              ext_clock_pin_two_in,
  input  wire logic              ext_clock_pin_b_in,
  input  wire logic              gate_pin_one_in,
  input  wire logic              gate_pin_two_in,
  input  wire logic              gate_pin_three_in,
  input  wire logic              cpu_idle_in,
  // Events and time bases
  output logic                   irq_out,
  output logic                   adc_trigger_out,
  output logic [15:0]            time_base_two_out,
  output logic [15:0]            time_base_three_out,
  output logic                   match_two_out,
  output logic                   match_three_out
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [15:0] ctrl   [3];
  logic [15:0] count  [3];
  logic [15:0] period [3];
  logic [15:0] next_ctrl   [3];
  logic [15:0] next_count  [3];
  logic [15:0] next_period [3];
  logic [15:0] ectl [3];
  logic [2:0]  status, next_status, mask, next_mask;
  logic [5:0]  pin_vec, ff1, ff2, ff3, lvl, lvl_d;
  logic [5:0]  next_lvl;
  logic [2:0]  live, presc_en, tick, gate_evt, ev, cnt_wr;
  logic        wide, raw_edge, pair_ev, wr_go, rd_go, rd_clr;
  logic        aw_got, w_got, next_aw_got, next_w_got;
  logic [7:0]  wa, next_wa, ra, next_ra;
  logic [15:0] wd, next_wd;
  logic [1:0]  ws, next_ws;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  bresp, rresp, next_bresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        irq, adc, m2, m3, next_irq, next_adc, next_m2, next_m3;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [15:0] val,
                                         input logic [1:0]  be,
                                         input logic [15:0] keep);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & keep;
    return (old & ~m) | (val & m);
  endfunction : wmerge

  // ------------------------------------------------------------------
  // Pin synchronisers: three stages, level moves when the last two stages agree
  // ------------------------------------------------------------------
  assign pin_vec = {gate_pin_three_in, gate_pin_two_in, gate_pin_one_in,
                    ext_clock_pin_b_in, ext_clock_pin_two_in, ext_clock_pin_one_in};

  generate
    for (genvar p = 0; p < 6; p++) begin : g_sync
      // Stable level update
      always_comb begin
        next_lvl[p] = (ff2[p] == ff3[p]) ? ff3[p] : lvl[p];
      end
      // Stage registers
      always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
          ff1[p]   <= 1'b0;
          ff2[p]   <= 1'b0;
          ff3[p]   <= 1'b0;
          lvl[p]   <= 1'b0;
          lvl_d[p] <= 1'b0;
        end else begin
          ff1[p]   <= pin_vec[p];
          ff2[p]   <= ff1[p];
          ff3[p]   <= ff2[p];
          lvl[p]   <= next_lvl[p];
          lvl_d[p] <= lvl[p];
        end
      end
    end
  endgenerate

  // Unfiltered edge for timer one asynchronous counting
  assign raw_edge = ff2[0] & ~ff3[0];
  assign wide     = ctrl[1][BIT_WIDE];

  // ------------------------------------------------------------------
  // Per-timer clock qualification
  // ------------------------------------------------------------------
  always_comb begin
    for (int t = 0; t < 3; t++) begin
      int unsigned pi;
      logic src_ok, gate_on, ext_e;
      pi = 0;
      src_ok = 1'b0;
      gate_on = 1'b0;
      ext_e = 1'b0;
      // Paired timer three follows timer two control
      ectl[t] = (t == 2 && wide) ? ctrl[1] : ctrl[t];
      pi = (t == 2 && wide) ? 1 : t;
      live[t] = ectl[t][BIT_RUN] && !(ectl[t][BIT_IDLE] && cpu_idle_in);
      // Synced edge, or raw edge for timer one with sync clear
      ext_e = (t == 0 && !ectl[0][BIT_SYNC]) ? raw_edge
            : (lvl[pi] & ~lvl_d[pi]);
      src_ok = ectl[t][BIT_SRC] ? ext_e : 1'b1;
      gate_on = ectl[t][BIT_GATE] && !ectl[t][BIT_SRC];
      presc_en[t] = live[t] && src_ok && (!gate_on || lvl[3 + pi])
                    && !(t == 2 && wide);
      gate_evt[t] = live[t] && gate_on && !lvl[3 + pi] && lvl_d[3 + pi]
                    && !(t == 2 && wide);
    end
  end

  generate
    for (genvar t = 0; t < 3; t++) begin : g_presc
      gpt_prescale u_presc (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .clear_in  (!live[t]),
        .step_in   (presc_en[t]),
        .select_in (ectl[t][BIT_PS_HI:BIT_PS_LO]),
        .tick_out  (tick[t])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Counters, registers, status and bus slave
  // ------------------------------------------------------------------
  always_comb begin
    logic [31:0] c32;
    logic [15:0] rv;
    logic        rerr, werr;
    c32 = {count[2], count[1]};
    rv = 16'h0000;
    rerr = 1'b0;
    werr = 1'b0;
    next_ctrl = ctrl;
    next_count = count;
    next_period = period;
    next_mask = mask;
    ev = 3'h0;
    pair_ev = 1'b0;
    // Independent counting with wrap on period match
    for (int t = 0; t < 3; t++) begin
      if (tick[t]) begin
        if (count[t] == period[t]) begin
          next_count[t] = COUNT_RST;
          ev[t] = 1'b1;
        end else begin
          next_count[t] = count[t] + 16'h0001;
        end
      end
    end
    // Paired 32-bit counting driven by timer two
    if (wide) begin
      ev[2:1] = 2'h0;
      next_count[2] = count[2];
      if (tick[1]) begin
        if (c32 == {period[2], period[1]}) begin
          next_count[1] = COUNT_RST;
          next_count[2] = COUNT_RST;
          pair_ev = 1'b1;
        end else begin
          {next_count[2], next_count[1]} = c32 + 32'h0000_0001;
        end
      end
    end
    // Gate falling edge events
    ev = ev | gate_evt;
    if (wide && gate_evt[1]) begin
      ev[1] = 1'b0;
      ev[2] = 1'b1;
    end
    // Write channel acceptance
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_wa = wa;
    next_wd = wd;
    next_ws = ws;
    if (s_axi_awvalid_in && awready) begin
      next_aw_got = 1'b1;
      next_wa = {s_axi_awaddr_in[7:2], 2'h0};
    end
    if (s_axi_wvalid_in && wready) begin
      next_w_got = 1'b1;
      next_wd = s_axi_wdata_in[15:0];
      next_ws = s_axi_wstrb_in[1:0];
    end
    wr_go = aw_got && w_got && !bvalid;
    cnt_wr = 3'h0;
    next_bvalid = bvalid && !s_axi_bready_in;
    next_bresp = bresp;
    if (wr_go) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      // Register writes, count and period take effect at once
      case (wa)
        OFF_CTRL1:   next_ctrl[0] = wmerge(ctrl[0], wd, ws, CTRL1_MASK);
        OFF_CTRL2:   next_ctrl[1] = wmerge(ctrl[1], wd, ws, CTRL2_MASK);
        OFF_CTRL3:   next_ctrl[2] = wmerge(ctrl[2], wd, ws, CTRL3_MASK);
        OFF_COUNT1:  cnt_wr[0] = 1'b1;
        OFF_COUNT2:  cnt_wr[1] = 1'b1;
        OFF_COUNT3:  cnt_wr[2] = 1'b1;
        OFF_PERIOD1: next_period[0] = wmerge(period[0], wd, ws, 16'hffff);
        OFF_PERIOD2: next_period[1] = wmerge(period[1], wd, ws, 16'hffff);
        OFF_PERIOD3: next_period[2] = wmerge(period[2], wd, ws, 16'hffff);
        OFF_MASK:    next_mask = ws[0] ? wd[2:0] : mask;
        OFF_STATUS:  werr = 1'b0;
        default:     werr = 1'b1;
      endcase
      for (int t = 0; t < 3; t++) begin
        if (cnt_wr[t]) begin
          next_count[t] = wmerge(count[t], wd, ws, 16'hffff);
        end
      end
      next_bresp = werr ? RESP_SLVERR : RESP_OKAY;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    // Read channel
    rd_go = s_axi_arvalid_in && arready;
    next_ra = rd_go ? {s_axi_araddr_in[7:2], 2'h0} : ra;
    case ({s_axi_araddr_in[7:2], 2'h0})
      OFF_CTRL1:   rv = ctrl[0] & CTRL1_MASK;
      OFF_CTRL2:   rv = ctrl[1] & CTRL2_MASK;
      OFF_CTRL3:   rv = ctrl[2] & CTRL3_MASK;
      OFF_COUNT1:  rv = count[0];
      OFF_COUNT2:  rv = count[1];
      OFF_COUNT3:  rv = count[2];
      OFF_PERIOD1: rv = period[0];
      OFF_PERIOD2: rv = period[1];
      OFF_PERIOD3: rv = period[2];
      OFF_STATUS:  rv = {13'h0000, status};
      OFF_MASK:    rv = {13'h0000, mask};
      default:     rerr = 1'b1;
    endcase
    rd_clr = rd_go && ({s_axi_araddr_in[7:2], 2'h0} == OFF_STATUS);
    next_rvalid = rvalid && !s_axi_rready_in;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, rv};
      next_rresp = rerr ? RESP_SLVERR : RESP_OKAY;
    end
    next_arready = !next_rvalid;
    // Sticky status: read clears, a new event wins
    next_status = (status & ~{3{rd_clr}}) | ev | {pair_ev, 2'h0};
    next_irq = |(next_status & next_mask);
    next_adc = pair_ev;
    next_m2 = ev[1];
    next_m3 = ev[2];
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      for (int t = 0; t < 3; t++) begin
        ctrl[t]   <= CTRL_RST;
        count[t]  <= COUNT_RST;
        period[t] <= PERIOD_RST;
      end
      status  <= STAT_RST;
      mask    <= STAT_RST;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      wa      <= 8'h00;
      ra      <= 8'h00;
      wd      <= 16'h0000;
      ws      <= 2'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
      irq     <= 1'b0;
      adc     <= 1'b0;
      m2      <= 1'b0;
      m3      <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      count   <= next_count;
      period  <= next_period;
      status  <= next_status;
      mask    <= next_mask;
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      wa      <= next_wa;
      ra      <= next_ra;
      wd      <= next_wd;
      ws      <= next_ws;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      irq     <= next_irq;
      adc     <= next_adc;
      m2      <= next_m2;
      m3      <= next_m3;
    end
  end

  // Output drive
  assign s_axi_awready_out   = awready;
  assign s_axi_wready_out    = wready;
  assign s_axi_bvalid_out    = bvalid;
  assign s_axi_bresp_out     = bresp;
  assign s_axi_arready_out   = arready;
  assign s_axi_rvalid_out    = rvalid;
  assign s_axi_rdata_out     = rdata;
  assign s_axi_rresp_out     = rresp;
  assign irq_out             = irq;
  assign adc_trigger_out     = adc;
  assign time_base_two_out   = count[1];
  assign time_base_three_out = count[2];
  assign match_two_out       = m2;
  assign match_three_out     = m3;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence ps8_quiet_s;
    (!tick[0] || ctrl[0][BIT_PS_HI:BIT_PS_LO] != 2'h1) [*7];
  endsequence

  sequence pair_wrap_s;
    wide && tick[1] && ({count[2], count[1]} == {period[2], period[1]}) && !wr_go
      && !gate_evt[1];
  endsequence

  idle_halt_a: assert property (
    (cpu_idle_in && ctrl[1][BIT_IDLE] && !cnt_wr[1]) |=> $stable(count[1]))
    else $error("timer two counted while halted in idle");
  gate_hold_a: assert property (
    (ctrl[0][BIT_GATE] && !ctrl[0][BIT_SRC] && !lvl[3] && !cnt_wr[0])
      |=> $stable(count[0]))
    else $error("gated timer one counted with gate low");
  presc_one_a: assert property (
    (live[0] && ctrl[0][BIT_PS_HI:BIT_PS_LO] == 2'h0 && !ctrl[0][BIT_SRC] && lvl[3]
      && count[0] != period[0] && !cnt_wr[0])
      |=> count[0] == $past(count[0]) + 16'h0001)
    else $error("timer one did not count every cycle at 1:1");
  presc_rate_a: assert property (
    (tick[0] && ctrl[0][BIT_PS_HI:BIT_PS_LO] == 2'h1) |=> ps8_quiet_s)
    else $error("timer one ticked sooner than 1:8");
  src_ext_a: assert property (
    (ctrl[0][BIT_SRC] && !ff2[0] && !lvl[0] && !cnt_wr[0]) |=> $stable(count[0]))
    else $error("external source counted without a pin edge");
  t3_ignored_a: assert property (
    (wide && !tick[1] && !cnt_wr[2]) |=> $stable(count[2]))
    else $error("paired high word moved without low word tick");
  pair_carry_a: assert property (
    (wide && tick[1] && count[1] == 16'hffff && !wr_go
      && ({count[2], count[1]} != {period[2], period[1]}))
      |=> count[2] == $past(count[2]) + 16'h0001 && count[1] == 16'h0000)
    else $error("low word overflow did not carry into high word");
  pair_irq_a: assert property (
    pair_wrap_s |=> status[2] && adc_trigger_out && !match_three_out)
    else $error("paired match did not flag timer three and trigger");
  adc_solo_a: assert property (
    !wide |=> !adc_trigger_out)
    else $error("converter trigger from an unpaired timer");
  read_zero_a: assert property (
    (rvalid && ra == OFF_CTRL1) |-> (rdata[15:0] & ~CTRL1_MASK) == 16'h0000)
    else $error("unimplemented control bit read as one");
  run_stop_a: assert property (
    (!ctrl[0][BIT_RUN] && !cnt_wr[0]) |=> $stable(count[0]))
    else $error("timer one counted while stopped");
  gate_irq_a: assert property (
    gate_evt[0] |=> status[0] ##1 1'b1)
    else $error("gate falling edge did not flag timer one");
  wrap_zero_a: assert property (
    (!wide && tick[1] && count[1] == period[1] && !cnt_wr[1]) |=> count[1] == 16'h0000)
    else $error("timer two did not wrap to zero on match");

endmodule : gpt_timers

`default_nettype wire

// ---- gpt_pins.sv ----
// Behavioural model of the external clock and gate pins
`default_nettype none

module gpt_pins (
  // Clock
  input  wire logic       mclk_in,
  // Commands from the bench
  input  wire logic       go_in,
  input  wire logic [7:0] edges_in,
  input  wire logic       gate_in,
  // Pins and status
  output logic            ext_clock_out,
  output logic            gate_out,
  output logic            busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left  = 8'h00;
  logic [1:0] phase = 2'h0;
  logic       level = 1'b0;

  // Gate follows the bench, burst status, pin from its own register
  assign gate_out      = gate_in;
  assign busy_out      = (left != 8'h00);
  assign ext_clock_out = level;

  // Pin clock toggles every 4 cycles in a burst, stands low between
  always @(posedge mclk_in) begin
    if (go_in) begin
      left <= edges_in;
    end else if (left != 8'h00) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        level <= ~level;
        if (level) begin
          left <= left - 8'h01;
        end
      end
    end
  end
endmodule : gpt_pins

`default_nettype wire

// ---- tb_general_purpose_timers.sv ----
// Self-checking bench for the general-purpose timers
`default_nettype none

module tb_general_purpose_timers;
  import gpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, idle, go, gate;
  logic        awready, wready, bvalid, arready, rvalid, irq, adc, m2, m3, ext, gp, busy;
  logic [7:0]  awaddr, araddr, edges;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] tb2, tb3, d;
  logic [15:0] msk [3];
  int          miscompares, n_compared, cyc, n_adc, n_m3, seed, t0, div, p, k;

  gpt_timers DUT (
    .mclk_in(mclk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .ext_clock_pin_one_in(ext), .ext_clock_pin_two_in(ext), .ext_clock_pin_b_in(ext),
    .gate_pin_one_in(gp), .gate_pin_two_in(gp), .gate_pin_three_in(gp),
    .cpu_idle_in(idle), .irq_out(irq), .adc_trigger_out(adc),
    .time_base_two_out(tb2), .time_base_three_out(tb3), .match_two_out(m2),
    .match_three_out(m3)
  );
  gpt_pins pins (.mclk_in(mclk), .go_in(go), .edges_in(edges), .gate_in(gate),
    .ext_clock_out(ext), .gate_out(gp), .busy_out(busy));

  // --------------------------------------------------------------
  // Clock, cycle and trigger counters, bus tasks
  // --------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (adc === 1'b1) n_adc <= n_adc + 1;
    if (m3 === 1'b1) n_m3 <= n_m3 + 1;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      if (bvalid) resp = bresp;
    end while (awvalid || wvalid || bready);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
      if (rvalid) q = rdata;
      if (rvalid) resp = rresp;
    end while (arvalid || rready);
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (e !== s) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic pulse();
    do @(posedge mclk); while (m2 !== 1'b1);
  endtask : pulse
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    results();
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, idle, go, gate} <= 9'h001;
    {awaddr, araddr, edges, wdata} <= 56'h0;
    seed = 32'h2b5a;
    msk = '{16'ha076, 16'ha07a, 16'ha072};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    for (k = 0; k < 11; k++) begin
      rd(8'(4 * k));
      chk("reset value", (k == 4 || k == 6 || k == 8) ? 32'hffff : 32'h0, q);
    end
    rd(8'h2c);
    chk("unmapped", RESP_SLVERR, resp);
    for (k = 0; k < 3; k++) begin
      wr(8'(4 * k), 16'hffff);
      rd(8'(4 * k));
      chk("control readback", msk[k], q);
      wr(8'(4 * k), 16'h0000);
    end
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      div = (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 64 : 256;
      p = 2 + ($random(seed) & 3);
      wr(OFF_PERIOD2, 16'(p));
      wr(OFF_COUNT2, 16'h0000);
      wr(OFF_CTRL2, 16'h8000 | 16'(k << 4));
      pulse();
      t0 = cyc;
      pulse();
      chk("match gap", (p + 1) * div, cyc - t0);
      wr(OFF_CTRL2, 16'h0000);
    end
    chk("adc unpaired", 0, n_adc);
    $display("test prescale done");
    idle <= 1'b1;
    wr(OFF_PERIOD2, 16'hffff);
    wr(OFF_CTRL2, 16'ha000);
    d = tb2;
    repeat (20) @(posedge mclk);
    chk("idle halt", d, tb2);
    wr(OFF_CTRL2, 16'h8000);
    d = tb2;
    repeat (20) @(posedge mclk);
    chk("idle run", 1, d != tb2);
    idle <= 1'b0;
    $display("test idle done");
    wr(OFF_CTRL2, 16'h0000);
    wr(OFF_COUNT2, 16'h0000);
    gate <= 1'b0;
    wr(OFF_CTRL2, 16'h8042);
    p = 3 + ($random(seed) & 7);
    edges <= 8'(p);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (3) @(posedge mclk);
    for (k = 0; k < 200 && busy; k++) @(posedge mclk);
    chk("pin burst end", 0, busy);
    repeat (8) @(posedge mclk);
    rd(OFF_COUNT2);
    chk("pin edges", p, q);
    $display("test pin clock done");
    wr(OFF_CTRL2, 16'h0000);
    wr(OFF_COUNT1, 16'h0000);
    wr(OFF_CTRL1, 16'h8040);
    rd(OFF_STATUS);
    repeat (20) @(posedge mclk);
    rd(OFF_COUNT1);
    chk("gate closed", 0, q);
    gate <= 1'b1;
    repeat (20) @(posedge mclk);
    gate <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("masked irq", 0, irq);
    wr(OFF_MASK, 16'h0001);
    chk("irq", 1, irq);
    rd(OFF_STATUS);
    chk("gate fall status", 1, q);
    chk("irq cleared", 0, irq);
    $display("test gate done");
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_CTRL2, 16'h0008);
    wr(OFF_CTRL3, 16'ha030);
    idle <= 1'b1;
    wr(OFF_PERIOD2, 16'h0001);
    wr(OFF_PERIOD3, 16'h0001);
    wr(OFF_COUNT2, 16'hfffe);
    wr(OFF_COUNT3, 16'h0000);
    wr(OFF_MASK, 16'h0004);
    rd(OFF_STATUS);
    wr(OFF_CTRL2, 16'h8008);
    repeat (12) @(posedge mclk);
    chk("adc paired", 1, n_adc);
    chk("pair irq", 1, irq);
    rd(OFF_COUNT3);
    chk("high word wrap", 0, q);
    chk("time base three", 0, tb3);
    chk("pair match three", 0, n_m3);
    rd(OFF_STATUS);
    chk("pair status", 4, q);
    $display("test paired done");
    results();
  end
endmodule : tb_general_purpose_timers

`default_nettype wire
